/* File: rtl/qrw_sequencer.sv */
// Command decoder, opcode skip and burst wrap logic of the quad read path.
module qrw_sequencer
	import qrw_pkg::*;
(
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Serial pins.
	input  wire logic       spi_sclk,
	input  wire logic       spi_cs_n,
	input  wire logic [3:0] spi_io_in,
	output logic      [3:0] spi_io_out,
	output logic      [3:0] spi_io_oe,
	// Configuration.
	input  wire logic       quad_lines_enable_bit,
	// Memory fetch requests.
	output logic            req_valid,
	output logic     [23:0] req_addr,
	input  wire logic       req_ready,
	// Memory fetch answers.
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_data,
	output logic            rsp_ready,
	// Status.
	output qrw_status_type  status
);

	logic          sclk_meta, sclk_s, sclk_d;
	logic          cs_meta, cs_s, cs_d;
	logic [3:0]    io_meta, io_s;
	logic          rise, fall, cs_rise, cs_fall, seq_rise;

	qrw_state_type state, next_state;
	qrw_cmd_type   cmd, next_cmd, skip_cmd, next_skip_cmd;
	logic [4:0]    cnt, next_cnt;
	logic [7:0]    opcode, next_opcode, mode_byte, next_mode;
	logic [23:0]   addr, next_addr;
	logic          skip, next_skip, in_skip_txn, next_in_skip;
	logic          all_ones, next_all_ones, start_fetch;
	logic [2:0]    burst_settings, next_burst;
	logic          is_dual, lanes_ones, mode_done;

	logic          fetching, next_fetching, next_req_valid, fire, rsp_take, push, pop;
	logic [23:0]   next_req_addr, lin_addr, wrap_addr;
	logic [1:0]    inflight, next_inflight, drop, next_drop;
	logic          wrap_on;
	logic [5:0]    mask;

	logic [7:0]    buf_mem [2];
	logic [7:0]    next_buf_mem [2];
	logic          wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr, next_rsp_ready;
	logic [1:0]    count, next_count;

	logic [7:0]    shift, next_shift, out_byte;
	logic [1:0]    nib_idx, next_nib_idx;
	logic [3:0]    next_io_out, next_io_oe;
	logic          underrun, next_underrun;
	qrw_status_type next_status;

	// The first stage only feeds the second, so metastability stays contained.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_meta <= 1'b0;
			sclk_s    <= 1'b0;
			sclk_d    <= 1'b0;
			cs_meta   <= 1'b1;
			cs_s      <= 1'b1;
			cs_d      <= 1'b1;
			io_meta   <= 4'h0;
			io_s      <= 4'h0;
		end else begin
			sclk_meta <= spi_sclk;
			sclk_s    <= sclk_meta;
			sclk_d    <= sclk_s;
			cs_meta   <= spi_cs_n;
			cs_s      <= cs_meta;
			cs_d      <= cs_s;
			io_meta   <= spi_io_in;
			io_s      <= io_meta;
		end
	end

	assign rise     = sclk_s & ~sclk_d;
	assign fall     = ~sclk_s & sclk_d;
	assign cs_rise  = cs_s & ~cs_d;
	assign cs_fall  = ~cs_s & cs_d;
	assign seq_rise = rise & ~cs_s & ~cs_fall;
	assign is_dual  = (cmd == CMD_DUAL);
	assign lanes_ones = is_dual ? (&io_s[1:0]) : (&io_s);
	assign mode_done = seq_rise && (state == ST_MODE) && (cnt == mode_clks(cmd) - 5'h01);

	always_comb begin
		next_state    = state;
		next_cmd      = cmd;
		next_cnt      = cnt;
		next_opcode   = opcode;
		next_addr     = addr;
		next_mode     = mode_byte;
		next_skip     = skip;
		next_skip_cmd = skip_cmd;
		next_burst    = burst_settings;
		next_in_skip  = in_skip_txn;
		next_all_ones = all_ones;
		start_fetch   = 1'b0;
		if (cs_rise) begin
			next_state   = ST_IDLE;
			next_in_skip = 1'b0;
			// An all-ones skip frame that ends before its mode byte is complete is the mode reset.
			if (in_skip_txn && all_ones && (state == ST_ADDR || state == ST_MODE)) begin
				next_skip = 1'b0;
			end
		end else if (cs_fall) begin
			next_cnt      = 5'h00;
			next_all_ones = 1'b1;
			if (skip) begin
				next_state   = ST_ADDR;
				next_cmd     = skip_cmd;
				next_in_skip = 1'b1;
			end else begin
				next_state = ST_OPCODE;
				next_cmd   = CMD_NONE;
			end
		end else if (seq_rise) begin
			next_cnt = cnt + 5'h01;
			unique case (state)
				ST_IDLE, ST_DATA, ST_IGNORE: begin
					next_cnt = cnt;
				end
				ST_OPCODE: begin
					next_opcode = {opcode[6:0], io_s[0]};
					if (cnt == OPCODE_CLKS - 5'h01) begin
						next_cnt   = 5'h00;
						next_state = ST_ADDR;
						unique case (next_opcode)
							OP_DUAL_IO: begin
								next_cmd = CMD_DUAL;
							end
							OP_QUAD_IO: begin
								next_cmd = CMD_QUAD;
								if (!quad_lines_enable_bit) begin
									next_state = ST_IGNORE;
								end
							end
							OP_WORD_IO: begin
								next_cmd = CMD_WORD;
								if (!quad_lines_enable_bit) begin
									next_state = ST_IGNORE;
								end
							end
							OP_OCTAL_IO: begin
								next_cmd = CMD_OCTAL;
								if (!quad_lines_enable_bit) begin
									next_state = ST_IGNORE;
								end
							end
							OP_BURST_SETUP: begin
								next_state = ST_WRAP;
							end
							default: begin
								next_state = ST_IGNORE;
							end
						endcase
					end
				end
				ST_ADDR: begin
					// Address moves high bits first on the widest lane set of the command.
					next_addr = is_dual ? {addr[21:0], io_s[1:0]} : {addr[19:0], io_s};
					next_all_ones = all_ones & lanes_ones;
					if (cnt == addr_clks(cmd) - 5'h01) begin
						next_cnt    = 5'h00;
						next_state  = ST_MODE;
						start_fetch = 1'b1;
					end
				end
				ST_MODE: begin
					next_mode = is_dual ? {mode_byte[5:0], io_s[1:0]} : {mode_byte[3:0], io_s};
					next_all_ones = all_ones & lanes_ones;
					if (cnt == mode_clks(cmd) - 5'h01) begin
						next_cnt      = 5'h00;
						// Only the continuation field is looked at; the rest is free.
						next_skip     = (next_mode[SKIP_FIELD_LSB +: 2] == SKIP_CODE);
						next_skip_cmd = cmd;
						if (dummy_clks(cmd) == DUMMY_NONE) begin
							next_state = ST_DATA;
						end else begin
							next_state = ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					if (cnt == dummy_clks(cmd) - 5'h01) begin
						next_cnt   = 5'h00;
						next_state = ST_DATA;
					end
				end
				ST_WRAP: begin
					next_mode = {mode_byte[3:0], io_s};
					if (cnt == BURST_CLKS - 5'h01) begin
						next_burst = next_mode[BURST_SET_LSB +: 3];
						next_state = ST_IGNORE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state          <= ST_IDLE;
			cmd            <= CMD_NONE;
			cnt            <= 5'h00;
			opcode         <= 8'h00;
			addr           <= 24'h00_0000;
			mode_byte      <= 8'h00;
			skip           <= 1'b0;
			skip_cmd       <= CMD_NONE;
			burst_settings <= BURST_POWER_ON;
			in_skip_txn    <= 1'b0;
			all_ones       <= 1'b0;
		end else begin
			state          <= next_state;
			cmd            <= next_cmd;
			cnt            <= next_cnt;
			opcode         <= next_opcode;
			addr           <= next_addr;
			mode_byte      <= next_mode;
			skip           <= next_skip;
			skip_cmd       <= next_skip_cmd;
			burst_settings <= next_burst;
			in_skip_txn    <= next_in_skip;
			all_ones       <= next_all_ones;
		end
	end

	// Requests are prefetched from the end of the address while mode and dummy clocks shift in.
	assign fire     = req_valid & req_ready;
	assign rsp_take = rsp_valid & rsp_ready;
	assign push     = rsp_take & (drop == 2'h0);
	assign wrap_on  = ~burst_settings[SET_DIS_BIT] & (cmd == CMD_QUAD || cmd == CMD_WORD);
	assign mask     = burst_mask(burst_settings[SET_LEN_LSB +: 2]);
	assign lin_addr = req_addr + 24'h00_0001;
	assign wrap_addr = {req_addr[23:6], (req_addr[5:0] & ~mask) | (lin_addr[5:0] & mask)};

	always_comb begin
		next_fetching = fetching;
		next_req_addr = req_addr;
		next_drop     = drop;
		next_inflight = inflight + {1'b0, fire} - {1'b0, rsp_take};
		if (rsp_take && drop != 2'h0) begin
			next_drop = drop - 2'h1;
		end
		if (fire) begin
			next_req_addr = wrap_on ? wrap_addr : lin_addr;
		end
		if (start_fetch) begin
			next_fetching = 1'b1;
			next_req_addr = next_addr;
		end
		// Answers still in flight at frame end are thrown away on arrival.
		if (cs_rise) begin
			next_fetching = 1'b0;
			next_drop     = next_inflight;
		end
		next_req_valid = next_fetching && ((next_inflight + next_count) < BUF_DEPTH);
		if (req_valid && !fire && !cs_rise) begin
			next_req_valid = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetching  <= 1'b0;
			req_valid <= 1'b0;
			req_addr  <= 24'h00_0000;
			inflight  <= 2'h0;
			drop      <= 2'h0;
		end else begin
			fetching  <= next_fetching;
			req_valid <= next_req_valid;
			req_addr  <= next_req_addr;
			inflight  <= next_inflight;
			drop      <= next_drop;
		end
	end

	// Two-entry buffer between the memory answers and the output shifter.
	always_comb begin
		next_buf_mem = buf_mem;
		next_wr_ptr  = wr_ptr;
		next_rd_ptr  = rd_ptr;
		next_count   = count + {1'b0, push} - {1'b0, pop};
		if (push) begin
			next_buf_mem[wr_ptr] = rsp_data;
			next_wr_ptr          = ~wr_ptr;
		end
		if (pop) begin
			next_rd_ptr = ~rd_ptr;
		end
		if (cs_rise) begin
			next_count  = 2'h0;
			next_rd_ptr = next_wr_ptr;
		end
		next_rsp_ready = (next_count < BUF_DEPTH);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_mem[0] <= 8'h00;
			buf_mem[1] <= 8'h00;
			wr_ptr     <= 1'b0;
			rd_ptr     <= 1'b0;
			count      <= 2'h0;
			rsp_ready  <= 1'b1;
		end else begin
			buf_mem    <= next_buf_mem;
			wr_ptr     <= next_wr_ptr;
			rd_ptr     <= next_rd_ptr;
			count      <= next_count;
			rsp_ready  <= next_rsp_ready;
		end
	end

	// A starved shifter sends ones rather than stalling, since the serial clock cannot wait.
	assign out_byte = (count != 2'h0) ? buf_mem[rd_ptr] : UNDERRUN_BYTE;
	assign pop = fall && !cs_s && (state == ST_DATA) && (nib_idx == 2'h0) && (count != 2'h0);

	always_comb begin
		next_shift    = shift;
		next_nib_idx  = nib_idx;
		next_io_out   = spi_io_out;
		next_io_oe    = spi_io_oe;
		next_underrun = underrun;
		if (cs_fall) begin
			next_underrun = 1'b0;
		end
		if (cs_rise) begin
			next_io_oe   = 4'h0;
			next_nib_idx = 2'h0;
		end else if (fall && !cs_s && state == ST_DATA) begin
			if (nib_idx == 2'h0) begin
				if (count == 2'h0) begin
					next_underrun = 1'b1;
				end
				next_io_out = is_dual ? {2'h0, out_byte[7:6]} : out_byte[7:4];
				next_shift  = is_dual ? {out_byte[5:0], 2'h0} : {out_byte[3:0], 4'h0};
			end else begin
				next_io_out = is_dual ? {2'h0, shift[7:6]} : shift[7:4];
				next_shift  = is_dual ? {shift[5:0], 2'h0} : {shift[3:0], 4'h0};
			end
			if (nib_idx == (is_dual ? LAST_NIB_DUAL : LAST_NIB_QUAD)) begin
				next_nib_idx = 2'h0;
			end else begin
				next_nib_idx = nib_idx + 2'h1;
			end
			next_io_oe = is_dual ? 4'h3 : 4'hF;
		end
		next_status = '{skip_active: next_skip, skip_cmd: next_skip_cmd,
			burst_settings: next_burst, active_cmd: next_cmd, underrun: next_underrun};
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift      <= 8'h00;
			nib_idx    <= 2'h0;
			spi_io_out <= 4'h0;
			spi_io_oe  <= 4'h0;
			underrun   <= 1'b0;
			status     <= '{skip_active: 1'b0, skip_cmd: CMD_NONE,
				burst_settings: BURST_POWER_ON, active_cmd: CMD_NONE, underrun: 1'b0};
		end else begin
			shift      <= next_shift;
			nib_idx    <= next_nib_idx;
			spi_io_out <= next_io_out;
			spi_io_oe  <= next_io_oe;
			underrun   <= next_underrun;
			status     <= next_status;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	property p_word_dummy;
		(seq_rise && state == ST_DUMMY && cmd == CMD_WORD)
			|=> ((state == ST_DATA) == ($past(cnt) == 5'h01));
	endproperty
	a_word_dummy: assert property (p_word_dummy) else $error("word read dummy count wrong");

	property p_quad_dummy;
		(seq_rise && state == ST_DUMMY && cmd == CMD_QUAD)
			|=> ((state == ST_DATA) == ($past(cnt) == 5'h03));
	endproperty
	a_quad_dummy: assert property (p_quad_dummy) else $error("quad read dummy count wrong");

	property p_octal_no_dummy;
		(mode_done && cmd == CMD_OCTAL) |=> (state == ST_DATA);
	endproperty
	a_octal_no_dummy: assert property (p_octal_no_dummy) else $error("octal read waited");

	property p_qe_word;
		(seq_rise && state == ST_OPCODE && cnt == 5'h07 && !quad_lines_enable_bit
			&& {opcode[6:0], io_s[0]} == OP_WORD_IO) |=> (state == ST_IGNORE);
	endproperty
	a_qe_word: assert property (p_qe_word) else $error("word read taken without enable");

	property p_qe_octal;
		(seq_rise && state == ST_OPCODE && cnt == 5'h07 && !quad_lines_enable_bit
			&& {opcode[6:0], io_s[0]} == OP_OCTAL_IO) |=> (state == ST_IGNORE);
	endproperty
	a_qe_octal: assert property (p_qe_octal) else $error("octal read taken without enable");

	property p_skip_entry;
		(cs_fall && skip) |=> (state == ST_ADDR && cmd == $past(skip_cmd));
	endproperty
	a_skip_entry: assert property (p_skip_entry) else $error("skip frame not started at address");

	property p_normal_entry;
		(cs_fall && !skip) |=> (state == ST_OPCODE);
	endproperty
	a_normal_entry: assert property (p_normal_entry) else $error("normal frame skipped opcode");

	property p_mode_field;
		mode_done |=> (skip == (mode_byte[SKIP_FIELD_LSB +: 2] == SKIP_CODE));
	endproperty
	a_mode_field: assert property (p_mode_field) else $error("skip flag not from bits 5-4");

	property p_burst_capture;
		(seq_rise && state == ST_WRAP && cnt == 5'h07) |=> (burst_settings == $past(mode_byte[2:0]));
	endproperty
	a_burst_capture: assert property (p_burst_capture) else $error("wrap byte captured wrong");

	property p_burst_hold;
		!(seq_rise && state == ST_WRAP) |=> $stable(burst_settings);
	endproperty
	a_burst_hold: assert property (p_burst_hold) else $error("wrap setting changed");

	property p_wrap_section;
		(fire && wrap_on && !start_fetch && !cs_rise)
			|=> ((req_addr[23:0] & ~{18'h0_0000, mask}) == ($past(req_addr) & ~{18'h0_0000, mask}));
	endproperty
	a_wrap_section: assert property (p_wrap_section) else $error("wrap left its section");

	property p_shift_on_fall;
		!$stable(spi_io_out) |-> $past(fall);
	endproperty
	a_shift_on_fall: assert property (p_shift_on_fall) else $error("data moved off a falling edge");

	c_skip_frame: cover property (cs_fall && skip);
	c_wrap_fetch: cover property (fire && wrap_on);
	c_octal_data: cover property (state == ST_DATA && cmd == CMD_OCTAL && fall);
	c_mode_reset: cover property (cs_rise && in_skip_txn && all_ones);

endmodule

/* File: rtl/qrw_pkg.sv */
// Shared constants, types and helper functions of the quad read and burst wrap sequencer.
// How it works
// - Word quad read: host sends address bit 0 low; two dummy clocks follow mode.
// - Word quad read is accepted only while the quad enable bit is set.
// - Continuation field 10 makes the next frame skip the opcode, starting with address.
// - Any other continuation value returns the device to normal opcode decoding.
// - Mode byte bits 7-6 and 3-0 are ignored; only bits 5-4 matter.
// - Octal word quad read: four low address bits zero, no dummy clocks.
// - Octal word quad read is accepted only while the quad enable bit is set.
// - Burst setup: opcode, 24 dummy bits, wrap byte; bits 7 and 3-0 ignored.
// - Disable bit 0 enables wrap with 8/16/32/64 byte length; 1 disables it.
// - Wrap setting holds until the next burst setup and steers quad and word reads.
// - Wrapped reads start at the address and loop inside the aligned section.
// - The wrap disable bit is one after power-on.
// - The mode reset sequence forces the release bit and ends opcode skipping.
// - No opcodes are decoded while skipping; host sends mode reset first.
// - Opcode skipping applies only to dual, quad, word and octal word reads.
// - Standard quad read needs four dummy clocks after the mode byte.
// - Dual read moves address and data two bits per clock on two lines.
package qrw_pkg;

	localparam logic [7:0] OP_DUAL_IO     = 8'hBB;
	localparam logic [7:0] OP_QUAD_IO     = 8'hEB;
	localparam logic [7:0] OP_WORD_IO     = 8'hE7;
	localparam logic [7:0] OP_OCTAL_IO    = 8'hE3;
	localparam logic [7:0] OP_BURST_SETUP = 8'h77;

	localparam logic [4:0] OPCODE_CLKS    = 5'h08;
	localparam logic [4:0] ADDR_CLKS_QUAD = 5'h06;
	localparam logic [4:0] ADDR_CLKS_DUAL = 5'h0C;
	localparam logic [4:0] MODE_CLKS_QUAD = 5'h02;
	localparam logic [4:0] MODE_CLKS_DUAL = 5'h04;
	localparam logic [4:0] DUMMY_QUAD     = 5'h04;
	localparam logic [4:0] DUMMY_WORD     = 5'h02;
	localparam logic [4:0] DUMMY_NONE     = 5'h00;
	localparam logic [4:0] BURST_CLKS     = 5'h08;

	localparam int         SKIP_FIELD_LSB = 4;
	localparam logic [1:0] SKIP_CODE      = 2'h2;
	localparam int         BURST_SET_LSB  = 4;
	localparam int         SET_DIS_BIT    = 0;
	localparam int         SET_LEN_LSB    = 1;
	localparam logic [2:0] BURST_POWER_ON = 3'h1;

	localparam logic [1:0] BUF_DEPTH      = 2'h2;
	localparam logic [1:0] LAST_NIB_QUAD  = 2'h1;
	localparam logic [1:0] LAST_NIB_DUAL  = 2'h3;
	localparam logic [7:0] UNDERRUN_BYTE  = 8'hFF;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_OPCODE = 3'b001,
		ST_ADDR   = 3'b010,
		ST_MODE   = 3'b011,
		ST_DUMMY  = 3'b100,
		ST_DATA   = 3'b101,
		ST_WRAP   = 3'b110,
		ST_IGNORE = 3'b111
	} qrw_state_type;

	typedef enum logic [2:0] {
		CMD_NONE  = 3'b000,
		CMD_DUAL  = 3'b001,
		CMD_QUAD  = 3'b010,
		CMD_WORD  = 3'b011,
		CMD_OCTAL = 3'b100
	} qrw_cmd_type;

	typedef struct packed {
		logic        skip_active;
		qrw_cmd_type skip_cmd;
		logic [2:0]  burst_settings;
		qrw_cmd_type active_cmd;
		logic        underrun;
	} qrw_status_type;

	function automatic logic [4:0] addr_clks(input qrw_cmd_type c);
		return (c == CMD_DUAL) ? ADDR_CLKS_DUAL : ADDR_CLKS_QUAD;
	endfunction

	function automatic logic [4:0] mode_clks(input qrw_cmd_type c);
		return (c == CMD_DUAL) ? MODE_CLKS_DUAL : MODE_CLKS_QUAD;
	endfunction

	function automatic logic [4:0] dummy_clks(input qrw_cmd_type c);
		logic [4:0] d;
		d = DUMMY_NONE;
		if (c == CMD_QUAD) begin
			d = DUMMY_QUAD;
		end else if (c == CMD_WORD) begin
			d = DUMMY_WORD;
		end
		return d;
	endfunction

	function automatic logic [5:0] burst_mask(input logic [1:0] len);
		logic [5:0] m;
		m = 6'h07;
		unique case (len)
			2'h0: m = 6'h07;
			2'h1: m = 6'h0F;
			2'h2: m = 6'h1F;
			2'h3: m = 6'h3F;
		endcase
		return m;
	endfunction

endpackage

/* File: test/qrw_host_model.sv */
// Host-side serial controller model that clocks quad and dual read frames.
module qrw_host_model (
	// Clock.
	input  wire logic       sys_clk,
	// Serial pins.
	input  wire logic [3:0] io_wire,
	output logic            spi_sclk,
	output logic            spi_cs_n,
	output logic      [3:0] host_io,
	output logic            host_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] last_rd;

	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		host_io = 4'h0;
		host_oe = 1'b0;
	end

	// The high phase lasts four system clocks and the low phase at least five, so the device synchroniser sees every edge.
	task automatic tick(input logic [3:0] v, input bit drv, input bit rel);
		@(posedge sys_clk);
		#1;
		host_io = v;
		host_oe = drv;
		repeat (4) @(posedge sys_clk);
		#1;
		spi_sclk = 1'b1;
		last_rd = io_wire;
		repeat (2) @(posedge sys_clk);
		#1;
		// Released only once the device synchroniser holds the last driven nibble.
		if (rel) begin
			host_oe = 1'b0;
		end
		repeat (2) @(posedge sys_clk);
		#1;
		spi_sclk = 1'b0;
	endtask

	task automatic frame(input bit with_op, input logic [7:0] op, input logic [23:0] addr,
		input logic [7:0] mode, input int bpc, input int ndum, input int nb,
		output logic [7:0] data [$]);
		logic [31:0] seq;
		logic [7:0]  b;
		int          k;
		data = {};
		seq = {addr, mode};
		k = 32 / bpc;
		@(posedge sys_clk);
		#1;
		spi_cs_n = 1'b0;
		if (with_op) begin
			for (int i = 7; i >= 0; i--) begin
				tick({3'b000, op[i]}, 1'b1, 1'b0);
			end
		end
		for (int i = 0; i < k; i++) begin
			tick(bpc == 4 ? seq[31:28] : {2'b00, seq[31:30]}, 1'b1,
				i == k - 1 && ndum == 0);
			seq = seq << bpc;
		end
		for (int i = 0; i < ndum; i++) begin
			tick(4'h0, 1'b1, i == ndum - 1);
		end
		// Released lines carry a changing pattern so stale values cannot pass as data.
		for (int i = 0; i < nb * 8 / bpc; i++) begin
			tick(4'($urandom), 1'b0, 1'b0);
			b = (b << bpc) | (bpc == 4 ? 8'(last_rd) : 8'(last_rd[1:0]));
			if ((i + 1) % (8 / bpc) == 0) begin
				data.push_back(b);
			end
		end
		repeat (4) @(posedge sys_clk);
		#1;
		spi_cs_n = 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule

/* File: test/quad_io_read_wrap_control_bench.sv */
// Self-checking bench of the quad read sequencer with a behavioural fetch memory.
module quad_io_read_wrap_control_bench import qrw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic           sys_clk;
	logic           rst_n;
	logic           spi_sclk;
	logic           spi_cs_n;
	logic [3:0]     io_wire;
	logic [3:0]     io_out;
	logic [3:0]     io_oe;
	logic [3:0]     host_io;
	logic           host_oe;
	logic           qe;
	logic           req_valid;
	logic [23:0]    req_addr;
	logic           req_ready;
	logic           rsp_valid;
	logic [7:0]     rsp_data;
	logic           rsp_ready;
	qrw_status_type status;
	logic [7:0]     q [$];
	logic [7:0]     d [$];
	logic [7:0]     ops [3] = '{OP_QUAD_IO, OP_WORD_IO, OP_OCTAL_IO};
	logic [7:0]     op;
	logic [7:0]     m;
	logic [23:0]    a;
	logic           oe_seen;
	logic           stall;
	logic           hold;
	logic           wrap_on;
	logic [1:0]     wrap_len;
	int             n_errors;
	int             compares;
	int             cycles = 0;

	assign io_wire = (io_oe & io_out) | (~io_oe & (host_oe ? host_io : ~host_io));

	qrw_sequencer u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_io_in(io_wire), .spi_io_out(io_out), .spi_io_oe(io_oe),
		.quad_lines_enable_bit(qe), .req_valid(req_valid), .req_addr(req_addr),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_ready(rsp_ready), .status(status));

	qrw_host_model u_host (
		.sys_clk(sys_clk), .io_wire(io_wire), .spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n), .host_io(host_io), .host_oe(host_oe));

	function automatic logic [7:0] mem_byte(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h3C;
	endfunction

	function automatic logic [2:0] cmd_of(input logic [7:0] c);
		return c == OP_DUAL_IO ? CMD_DUAL : (c == OP_QUAD_IO ? CMD_QUAD :
			(c == OP_WORD_IO ? CMD_WORD : CMD_OCTAL));
	endfunction

	function automatic logic [23:0] exp_addr(input logic [23:0] x, input int k, input bit wr);
		logic [23:0] msk;
		msk = (24'h00_0008 << wrap_len) - 24'h00_0001;
		return wr ? ((x & ~msk) | ((x + 24'(k)) & msk)) : x + 24'(k);
	endfunction

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Memory answers every request in order, even after a frame ends: the device drops
	// those itself and would wait forever for an answer lost here. An offer stands until taken.
	always @(posedge sys_clk) begin
		hold = rsp_valid && !rsp_ready;
		if (rsp_valid && rsp_ready) void'(q.pop_front());
		if (req_valid && req_ready) q.push_back(mem_byte(req_addr));
		#1;
		req_ready = ($urandom % 4) != 0 && !stall;
		rsp_valid = hold || (q.size() > 0 && ($urandom % 3) != 0 && !stall);
		rsp_data = q.size() > 0 ? q[0] : 8'($urandom);
		if (io_oe != 4'h0) oe_seen = 1'b1;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_field(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd(input bit wo, input logic [7:0] c, input logic [23:0] x,
		input logic [7:0] md, input int nb);
		logic [7:0] r [$];
		int         nd;
		bit         wr;
		nd = c == OP_QUAD_IO ? 4 : (c == OP_WORD_IO ? 2 : 0);
		wr = wrap_on && (c == OP_QUAD_IO || c == OP_WORD_IO);
		u_host.frame(wo, c, x, md, c == OP_DUAL_IO ? 2 : 4, nd, nb, r);
		for (int k = 0; k < nb; k++) chk_data(r[k], mem_byte(exp_addr(x, k, wr)));
		chk_field(12'({status.active_cmd, status.underrun}), 12'({cmd_of(c), 1'b0}));
	endtask

	task automatic setw(input logic [1:0] len, input bit dis);
		u_host.frame(1, OP_BURST_SETUP, 24'($urandom),
			{1'($urandom), len, dis, 4'($urandom)}, 4, 0, 0, d);
		wrap_on = !dis;
		wrap_len = len;
		chk_field(12'(status.burst_settings), 12'({len, dis}));
	endtask

	task automatic done(input int t);
		$display("test %0d finished", t);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		qe = 1'b1;
		req_ready = 1'b0;
		rsp_valid = 1'b0;
		rsp_data = 8'h00;
		oe_seen = 1'b0;
		stall = 1'b0;
		wrap_on = 1'b0;
		wrap_len = 2'h0;
		n_errors = 0;
		compares = 0;
		void'($urandom(71));
		repeat (12) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge sys_clk);
		chk_field(12'(status), 12'({1'b0, CMD_NONE, BURST_POWER_ON, CMD_NONE, 1'b0}));
		// An all-ones frame outside skip mode is an unknown opcode and must change nothing.
		u_host.frame(0, 8'hFF, 24'hFF_FFFF, 8'hFF, 4, 0, 0, d);
		chk_field(12'(status), 12'({1'b0, CMD_NONE, BURST_POWER_ON, CMD_NONE, 1'b0}));
		done(1);
		rd(1, OP_QUAD_IO, 24'($urandom), 8'h00, 4);
		rd(1, OP_WORD_IO, {23'($urandom), 1'b0}, 8'hF0, 3);
		rd(1, OP_OCTAL_IO, {20'($urandom), 4'h0}, 8'h0F, 3);
		done(2);
		#1 qe = 1'b0;
		oe_seen = 1'b0;
		for (int i = 0; i < 3; i++) u_host.frame(1, ops[i], 24'($urandom), 8'h00, 4, 0, 2, d);
		chk_field(12'(oe_seen), 12'h000);
		#1 qe = 1'b1;
		// A memory that never answers starves the shifter, which must send ones and flag it.
		#1 stall = 1'b1;
		u_host.frame(1, OP_OCTAL_IO, 24'h00_0000, 8'h00, 4, 0, 2, d);
		chk_data(d[1], UNDERRUN_BYTE);
		chk_field(12'(status.underrun), 12'h001);
		#1 stall = 1'b0;
		done(3);
		for (int l = 0; l < 4; l++) begin
			setw(2'(l), 1'b0);
			rd(1, OP_QUAD_IO, {18'($urandom), 6'h3D}, 8'h00, 5);
		end
		rd(1, OP_WORD_IO, {18'($urandom), 6'h3C}, 8'h00, 6);
		rd(1, OP_OCTAL_IO, {18'($urandom), 6'h30}, 8'h00, 18);
		setw(2'($urandom), 1'b1);
		rd(1, OP_QUAD_IO, {18'($urandom), 6'h3E}, 8'h00, 4);
		done(4);
		rd(1, OP_QUAD_IO, 24'($urandom), {2'($urandom), 2'b10, 4'($urandom)}, 2);
		chk_field(12'({status.skip_active, status.skip_cmd}), 12'({1'b1, CMD_QUAD}));
		rd(0, OP_QUAD_IO, 24'($urandom), 8'h20, 2);
		rd(0, OP_QUAD_IO, 24'($urandom), 8'hC0, 2);
		chk_field(12'(status.skip_active), 12'h000);
		rd(1, OP_WORD_IO, {23'($urandom), 1'b0}, 8'h00, 2);
		done(5);
		rd(1, OP_WORD_IO, {23'($urandom), 1'b0}, 8'hA5, 2);
		chk_field(12'(status.skip_cmd), 12'(CMD_WORD));
		u_host.frame(0, 8'hFF, 24'hFF_FFFF, 8'hFF, 4, 0, 0, d);
		chk_field(12'(status.skip_active), 12'h000);
		rd(1, OP_OCTAL_IO, {20'($urandom), 4'h0}, 8'h00, 2);
		rd(1, OP_DUAL_IO, 24'($urandom), 8'h20, 3);
		chk_field(12'({status.skip_active, status.skip_cmd}), 12'({1'b1, CMD_DUAL}));
		rd(0, OP_DUAL_IO, 24'($urandom), 8'h20, 2);
		u_host.frame(0, 8'hFF, 24'hFF_FFFF, 8'hFF, 2, 0, 0, d);
		chk_field(12'(status.skip_active), 12'h000);
		done(6);
		setw(2'($urandom), 1'b0);
		for (int n = 0; n < 8; n++) begin
			op = ops[$urandom % 3];
			a = 24'($urandom);
			m = 8'($urandom);
			if (op == OP_WORD_IO) a[0] = 1'b0;
			if (op == OP_OCTAL_IO) a[3:0] = 4'h0;
			if (m[5:4] == 2'b10) m[5:4] = 2'b11;
			rd(1, op, a, m, 1 + $urandom % 4);
		end
		done(7);
		tally_and_finish();
	end
endmodule
